// [core/sgs_hyst_cmp.sv]
// level comparator with hysteresis for the gain switch selector.
// assumes an unsigned magnitude input, stable level and hysteresis settings.
`timescale 1ns/10ps
module sgs_hyst_cmp
	import sgs_pkg::*;
#(
	parameter int W = 16
)
(
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	input  wire logic [31:0]   i_q,
	input  wire logic [W-1:0]  i_level,
	input  wire logic [W-1:0]  i_hyst,
	output logic               o_high
);

	typedef struct packed {
		logic high;
	} sgs_cmp_s;

	sgs_cmp_s s;
	sgs_cmp_s n;

	// ==========================================================================
	// band logic: between the two edges the last decision holds
	always_comb
	begin
		n = s;
		if (i_q > 32'(i_level))
			n.high = 1'b1;
		else if (33'(i_q) + 33'(i_hyst) < 33'(i_level))
			n.high = 1'b0;
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= '0;
		else
			s <= n;
	end

	assign o_high = s.high;

	a_level_enter: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		i_q > 32'(i_level) |=> o_high)
		else $error("level exceeded but high not set");
	a_hyst_band: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(o_high && !(33'(i_q) + 33'(i_hyst) < 33'(i_level))) |=> o_high)
		else $error("high dropped inside hysteresis band");

endmodule // sgs_hyst_cmp

// [core/sgs_pkg.sv]
// constants shared by the gain switch selector: register map, condition codes,
// control modes and cycle counts.
// assumes a 20 MHz control clock and a 32-bit AXI4-Lite register bus.
package sgs_pkg;

	// ==========================================================================
	// timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int DELAY_UNIT_NS  = 100_000;
	localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_NS      = 1_000_000;
	localparam int SAMPLE_CYC     = SAMPLE_NS / CLK_PERIOD_NS;
	localparam int VAR_UNIT_RPM   = 10;
	localparam int VAR_SCALE      = (1_000_000_000 / SAMPLE_NS) / VAR_UNIT_RPM;

	// ==========================================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_COND   = 8'h00;
	localparam logic [7:0] ADDR_PAR0   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h28;
	localparam int PAR_N   = 9;
	localparam int PAR_POS = 0;
	localparam int PAR_VEL = 3;
	localparam int PAR_TRQ = 6;
	localparam int PAR_DLY = 0;
	localparam int PAR_LVL = 1;
	localparam int PAR_HYS = 2;
	localparam int COND_POS_LSB = 0;
	localparam int COND_VEL_LSB = 8;
	localparam int COND_TRQ_LSB = 16;
	localparam int ST_SECOND = 0;
	localparam int ST_INTEG  = 1;
	localparam int ST_G10    = 2;
	localparam int ST_HIGH   = 4;
	localparam int ST_MODE   = 8;
	localparam logic [3:0]  COND_RST = 4'h0;
	localparam logic [15:0] PAR_RST  = 16'h0000;
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	// ==========================================================================
	// condition codes
	localparam logic [3:0] C_FIX1      = 4'h0;
	localparam logic [3:0] C_FIX2      = 4'h1;
	localparam logic [3:0] C_INPUT     = 4'h2;
	localparam logic [3:0] C_TRQ       = 4'h3;
	localparam logic [3:0] C_INVALID   = 4'h4;
	localparam logic [3:0] C_VEL_VAR   = 4'h4;
	localparam logic [3:0] C_SPD_CMD   = 4'h5;
	localparam logic [3:0] C_POS_DEV   = 4'h6;
	localparam logic [3:0] C_CMD_EXIST = 4'h7;
	localparam logic [3:0] C_NOT_DONE  = 4'h8;
	localparam logic [3:0] C_SPEED     = 4'h9;
	localparam logic [3:0] C_CMD_VEL   = 4'hA;

	typedef enum logic [1:0] {
		MODE_POS  = 2'b00,
		MODE_VEL  = 2'b01,
		MODE_TRQ  = 2'b10,
		MODE_FULL = 2'b11
	} sgs_mode_e;

	typedef enum logic [1:0] {
		G_STALL  = 2'b00,
		G_ACTION = 2'b01,
		G_SETTLE = 2'b10
	} sgs_g10_e;

endpackage

// [core/sgs_return_delay.sv]
// second-gain hold with a return delay counted in 0.1 ms units.
// assumes a request that is high while the second gain is called for.
`timescale 1ns/10ps
module sgs_return_delay
	import sgs_pkg::*;
#(
	parameter int W        = 16,
	parameter int UNIT_CYC = DELAY_UNIT_CYC
)
(
	input  wire logic          i_clk,
	input  wire logic          i_arst_n,
	input  wire logic          i_req,
	input  wire logic          i_use_delay,
	input  wire logic [W-1:0]  i_delay,
	output logic               o_second
);

	typedef struct packed {
		logic          second;
		logic [W-1:0]  units;
		logic [31:0]   pre;
	} sgs_dly_s;

	sgs_dly_s s;
	sgs_dly_s n;

	// ==========================================================================
	// rising request wins at once; only the way back is timed
	always_comb
	begin
		n = s;
		if (i_req)
		begin
			n.second = 1'b1;
			n.units  = '0;
			n.pre    = '0;
		end
		else if (s.second)
		begin
			if (!i_use_delay || i_delay == '0)
				n.second = 1'b0;
			else if (s.pre == 32'(UNIT_CYC - 1))
			begin
				n.pre = '0;
				if (s.units == i_delay - 1'b1)
					n.second = 1'b0;
				else
					n.units = s.units + 1'b1;
			end
			else
				n.pre = s.pre + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			s <= '0;
		else
			s <= n;
	end

	assign o_second = s.second;

	a_rise_immediate: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		i_req |=> o_second)
		else $error("second gain delayed on entry");
	a_return_held: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(s.second && !i_req && i_use_delay && i_delay != '0 && s.pre == '0 && s.units == '0)
		|=> o_second)
		else $error("return to first gain skipped the delay");

endmodule // sgs_return_delay

// [core/sgs_selector.sv]
// gain switch selector: picks first or second gain set for the control loops.
// assumes synchronous inputs on i_clk, AXI4-Lite master with 8-bit addresses.
// Function
// - position/full-closed: code 0 first, 1 second, 2 external select input.
// - position/full-closed: code 4 is invalid and keeps first gain.
// - position deviation counted in encoder or scale pulses per control mode.
// - code 8: second gain while positioning not done, delay used, level ignored.
// - code 10: command presence plus actual speed, delay, level, hysteresis in r/min.
// - code 10 gives delay, level and hysteresis their special meanings.
// - velocity code 4: second gain on fast speed command change, no delay.
// - speed command variation unit is 10 r/min per second.
// - torque code 3: torque command variation with delay; codes 0..2 as usual.
// - delay applies only on return from second to first gain.
// - velocity control uses its own condition, delay, level and hysteresis.
// - torque control uses its own condition, delay, level and hysteresis.
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/10ps
module sgs_selector
	import sgs_pkg::*;
#(
	parameter int W          = 16,
	parameter int SAMPLE_LEN = SAMPLE_CYC
)
(
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  wire logic [7:0]   i_awaddr,
	input  wire logic         i_awvalid,
	output logic              o_awready,
	input  wire logic [31:0]  i_wdata,
	input  wire logic [3:0]   i_wstrb,
	input  wire logic         i_wvalid,
	output logic              o_wready,
	output logic [1:0]        o_bresp,
	output logic              o_bvalid,
	input  wire logic         i_bready,
	input  wire logic [7:0]   i_araddr,
	input  wire logic         i_arvalid,
	output logic              o_arready,
	output logic [31:0]       o_rdata,
	output logic [1:0]        o_rresp,
	output logic              o_rvalid,
	input  wire logic         i_rready,
	input  wire sgs_mode_e    i_ctrl_mode,
	input  wire logic         i_gain_select,
	input  wire logic signed [15:0] i_torque_cmd,
	input  wire logic signed [15:0] i_speed_cmd,
	input  wire logic signed [15:0] i_actual_speed,
	input  wire logic signed [31:0] i_pos_dev_enc,
	input  wire logic signed [31:0] i_pos_dev_scale,
	input  wire logic         i_pos_cmd_present,
	input  wire logic         i_positioning_done_flag,
	output logic              o_second_gain,
	output logic              o_integ_second
);

	typedef struct packed {
		logic                    aw_have;
		logic [7:0]              awaddr;
		logic                    w_have;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic [3:0]              cond_pos;
		logic [3:0]              cond_vel;
		logic [3:0]              cond_trq;
		logic [PAR_N-1:0][W-1:0] par;
		logic [31:0]             samp_cnt;
		logic signed [15:0]      prev_spd;
		logic signed [15:0]      prev_trq;
		logic [31:0]             spd_var;
		logic [31:0]             trq_var;
		sgs_g10_e                g10;
		logic                    second;
		logic                    integ;
	} sgs_top_s;

	sgs_top_s s;
	sgs_top_s n;

	logic        aw_h;
	logic        w_h;
	logic [7:0]  wa;
	logic [31:0] wd;
	logic [3:0]  ws;
	logic [3:0]  code;
	int          cset;
	logic        pos_side;
	logic        use_cmp;
	logic        raw;
	logic        use_dly;
	logic        is_g10;
	logic        req;
	logic [31:0] q;
	logic        cmp_high;
	logic        dly_second;

	function automatic logic [31:0] mag(input logic signed [32:0] v);
		logic signed [32:0] a;
		a = (v < 0) ? -v : v;
		return a[31:0];
	endfunction

	function automatic logic par_addr(input logic [7:0] a);
		return a >= ADDR_PAR0 && a < ADDR_STATUS && a[1:0] == 2'b00;
	endfunction

	// ==========================================================================
	// submodules
	sgs_hyst_cmp #(.W(W)) u_cmp (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_q      (q),
		.i_level  (s.par[cset + PAR_LVL]),
		.i_hyst   (s.par[cset + PAR_HYS]),
		.o_high   (cmp_high)
	);

	sgs_return_delay #(.W(W), .UNIT_CYC(DELAY_UNIT_CYC)) u_dly (
		.i_clk       (i_clk),
		.i_arst_n    (i_arst_n),
		.i_req       (is_g10 ? i_pos_cmd_present : req),
		.i_use_delay (use_dly),
		.i_delay     (s.par[cset + PAR_DLY]),
		.o_second    (dly_second)
	);

	// ==========================================================================
	// next state
	always_comb
	begin
		n = s;

		// register bus: address and data may arrive in either order
		aw_h = s.aw_have || (i_awvalid && o_awready);
		w_h  = s.w_have || (i_wvalid && o_wready);
		wa   = s.aw_have ? s.awaddr : i_awaddr;
		wd   = s.w_have ? s.wdata : i_wdata;
		ws   = s.w_have ? s.wstrb : i_wstrb;
		n.aw_have = aw_h;
		n.w_have  = w_h;
		if (i_awvalid && o_awready)
			n.awaddr = i_awaddr;
		if (i_wvalid && o_wready)
		begin
			n.wdata = i_wdata;
			n.wstrb = i_wstrb;
		end
		if (s.bvalid && i_bready)
			n.bvalid = 1'b0;
		if (aw_h && w_h && !s.bvalid)
		begin
			n.aw_have = 1'b0;
			n.w_have  = 1'b0;
			n.bvalid  = 1'b1;
			n.bresp   = RESP_OKAY;
			if (wa == ADDR_COND)
			begin
				if (ws[0])
					n.cond_pos = wd[COND_POS_LSB +: 4];
				if (ws[1])
					n.cond_vel = wd[COND_VEL_LSB +: 4];
				if (ws[2])
					n.cond_trq = wd[COND_TRQ_LSB +: 4];
			end
			else if (par_addr(wa))
			begin
				for (int b = 0; b < W / 8; b++)
					if (ws[b])
						n.par[(wa - ADDR_PAR0) >> 2][b*8 +: 8] = wd[b*8 +: 8];
			end
			else if (wa != ADDR_STATUS)
				n.bresp = RESP_SLVERR;
		end

		if (s.rvalid && i_rready)
			n.rvalid = 1'b0;
		if (i_arvalid && o_arready)
		begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			if (i_araddr == ADDR_COND)
			begin
				n.rdata[COND_POS_LSB +: 4] = s.cond_pos;
				n.rdata[COND_VEL_LSB +: 4] = s.cond_vel;
				n.rdata[COND_TRQ_LSB +: 4] = s.cond_trq;
			end
			else if (par_addr(i_araddr))
				n.rdata[W-1:0] = s.par[(i_araddr - ADDR_PAR0) >> 2];
			else if (i_araddr == ADDR_STATUS)
			begin
				n.rdata[ST_SECOND]    = s.second;
				n.rdata[ST_INTEG]     = s.integ;
				n.rdata[ST_G10 +: 2]  = s.g10;
				n.rdata[ST_HIGH]      = cmp_high;
				n.rdata[ST_MODE +: 2] = i_ctrl_mode;
			end
			else
				n.rresp = RESP_SLVERR;
		end

		// command variation, sampled once per millisecond
		if (s.samp_cnt == 32'(SAMPLE_LEN - 1))
		begin
			n.samp_cnt = 32'h0000_0000;
			n.prev_spd = i_speed_cmd;
			n.prev_trq = i_torque_cmd;
			n.spd_var  = 32'(mag(33'(i_speed_cmd) - 33'(s.prev_spd)) * VAR_SCALE);
			n.trq_var  = mag(33'(i_torque_cmd) - 33'(s.prev_trq));
		end
		else
			n.samp_cnt = s.samp_cnt + 32'h0000_0001;

		// velocity and torque control each own a condition code and a parameter set; position and full-closed share one
		cset     = PAR_POS;
		code     = s.cond_pos;
		pos_side = 1'b0;
		unique case (i_ctrl_mode)
			MODE_VEL:
			begin
				cset = PAR_VEL;
				code = s.cond_vel;
			end
			MODE_TRQ:
			begin
				cset = PAR_TRQ;
				code = s.cond_trq;
			end
			MODE_POS, MODE_FULL:
				pos_side = 1'b1;
		endcase

		q       = 32'h0000_0000;
		use_cmp = 1'b0;
		raw     = 1'b0;
		use_dly = 1'b0;
		is_g10  = 1'b0;
		if (code == C_FIX2)
			raw = 1'b1;
		else if (code == C_INPUT)
			raw = i_gain_select;
		else if (pos_side)
		begin
			use_dly = 1'b1;
			use_cmp = 1'b1;
			case (code)
				C_TRQ:       q = mag(33'(i_torque_cmd));
				C_SPD_CMD:   q = mag(33'(i_speed_cmd));
				C_POS_DEV:   q = (i_ctrl_mode == MODE_FULL) ? mag(33'(i_pos_dev_scale)) : mag(33'(i_pos_dev_enc));
				C_SPEED:     q = mag(33'(i_actual_speed));
				C_CMD_VEL:
				begin
					is_g10 = 1'b1;
					q      = mag(33'(i_actual_speed));
				end
				C_CMD_EXIST:
				begin
					use_cmp = 1'b0;
					raw     = i_pos_cmd_present;
				end
				C_NOT_DONE:
				begin
					use_cmp = 1'b0;
					raw     = !i_positioning_done_flag;
				end
				default:
				begin
					use_cmp = 1'b0;
					use_dly = 1'b0;
				end
			endcase
		end
		else if (i_ctrl_mode == MODE_VEL)
		begin
			use_cmp = code == C_TRQ || code == C_VEL_VAR || code == C_SPD_CMD;
			use_dly = code == C_TRQ || code == C_SPD_CMD;
			if (code == C_TRQ)
				q = mag(33'(i_torque_cmd));
			else if (code == C_VEL_VAR)
				q = s.spd_var;
			else
				q = mag(33'(i_speed_cmd));
		end
		else if (code == C_TRQ)
		begin
			use_cmp = 1'b1;
			use_dly = 1'b1;
			q       = s.trq_var;
		end
		req = use_cmp ? cmp_high : raw;

		// code 10: delayed command presence, then settle until near stall
		if (!is_g10)
			n.g10 = G_STALL;
		else if (dly_second)
			n.g10 = G_ACTION;
		else
		begin
			unique case (s.g10)
				G_ACTION: n.g10 = G_SETTLE;
				G_SETTLE: n.g10 = cmp_high ? G_SETTLE : G_STALL;
				G_STALL:  n.g10 = cmp_high ? G_SETTLE : G_STALL;
				default:  n.g10 = G_STALL;
			endcase
		end
		n.second = is_g10 ? (n.g10 == G_ACTION) : dly_second;
		n.integ  = is_g10 ? (n.g10 != G_STALL) : dly_second;
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s          <= '0;
			s.cond_pos <= COND_RST;
			s.cond_vel <= COND_RST;
			s.cond_trq <= COND_RST;
			s.par      <= {PAR_N{PAR_RST}};
			s.g10      <= G_STALL;
		end
		else
			s <= n;
	end

	// ==========================================================================
	// outputs
	assign o_awready      = !s.aw_have && !s.bvalid;
	assign o_wready       = !s.w_have && !s.bvalid;
	assign o_bvalid       = s.bvalid;
	assign o_bresp        = s.bresp;
	assign o_arready      = !s.rvalid;
	assign o_rvalid       = s.rvalid;
	assign o_rdata        = s.rdata;
	assign o_rresp        = s.rresp;
	assign o_second_gain  = s.second;
	assign o_integ_second = s.integ;

	// ==========================================================================
	// checks
	a_fixed_first: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(pos_side && code == C_FIX1)[*3] |-> !o_second_gain)
		else $error("code 0 did not hold first gain");
	a_fixed_second: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(code == C_FIX2)[*3] |-> o_second_gain)
		else $error("code 1 did not hold second gain");
	a_ext_select: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(code == C_INPUT && i_gain_select)[*3] |-> o_second_gain)
		else $error("gain select input ignored");
	a_invalid_code: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(pos_side && code == C_INVALID)[*3] |-> !o_second_gain)
		else $error("invalid code left second gain on");
	a_not_done: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(pos_side && code == C_NOT_DONE && !i_positioning_done_flag)[*3] |-> o_second_gain)
		else $error("positioning not done but first gain");
	a_vel_var_fast: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(i_ctrl_mode == MODE_VEL && code == C_VEL_VAR && !cmp_high)[*3] |-> !o_second_gain)
		else $error("variation condition applied a delay");
	a_g10_action: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(is_g10 && i_pos_cmd_present)[*2] |=> (o_second_gain && o_integ_second))
		else $error("command present but not full second gain");
	a_g10_settle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(is_g10 && !dly_second && s.g10 == G_ACTION) |=> (!o_second_gain && o_integ_second))
		else $error("settling stage gain split wrong");

endmodule // sgs_selector

// [sim/sgs_host_model.sv]
// host side of the gain selector: control mode, gain select input and loop quantities.
// assumes one bench process calls drive(); every value changes just after a rising edge.
`timescale 1ns/10ps
module sgs_host_model
	import sgs_pkg::*;
(
	input  wire logic          i_clk,
	output sgs_mode_e          o_ctrl_mode,
	output logic               o_gain_select,
	output logic signed [15:0] o_torque_cmd,
	output logic signed [15:0] o_speed_cmd,
	output logic signed [15:0] o_actual_speed,
	output logic signed [31:0] o_pos_dev_enc,
	output logic signed [31:0] o_pos_dev_scale,
	output logic               o_pos_cmd_present,
	output logic               o_positioning_done_flag
);
	// ==========================================================================
	// drive
	initial
	begin
		o_ctrl_mode = MODE_POS;
		{o_gain_select, o_torque_cmd, o_speed_cmd, o_actual_speed} = '0;
		{o_pos_dev_enc, o_pos_dev_scale, o_pos_cmd_present, o_positioning_done_flag} = '0;
	end

	// levels are held until the next call, as a real host holds its command lines
	task automatic drive(input sgs_mode_e m, input logic g, input logic signed [15:0] t, s, a,
		input logic signed [31:0] e, c, input logic p, d);
		@(posedge i_clk);
		o_ctrl_mode             <= m;
		o_gain_select           <= g;
		o_torque_cmd            <= t;
		o_speed_cmd             <= s;
		o_actual_speed          <= a;
		o_pos_dev_enc           <= e;
		o_pos_dev_scale         <= c;
		o_pos_cmd_present       <= p;
		o_positioning_done_flag <= d;
	endtask
endmodule // sgs_host_model

// [sim/tb.sv]
// self-checking bench for the gain switch selector.
// assumes the host model drives the loop side and this module is the AXI4-Lite master.
`timescale 1ns/10ps
module tb;
	import sgs_pkg::*;
	localparam int SL = 20;
	logic        i_clk;
	logic        i_arst_n = 1'b0;
	logic [7:0]  i_awaddr = '0, i_araddr = '0;
	logic [31:0] i_wdata = '0;
	logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_second_gain, o_integ_second;
	logic [1:0]  o_bresp, o_rresp, br, rr;
	logic [31:0] o_rdata, rd;
	sgs_mode_e   md;
	logic        gs, pc, pd;
	logic signed [15:0] tq, sp, ac;
	logic signed [31:0] pe, ps;
	int          err_count = 0;
	int          checks = 0;

	sgs_host_model i_sgs_host_model (.i_clk(i_clk), .o_ctrl_mode(md), .o_gain_select(gs), .o_torque_cmd(tq),
		.o_speed_cmd(sp), .o_actual_speed(ac), .o_pos_dev_enc(pe), .o_pos_dev_scale(ps),
		.o_pos_cmd_present(pc), .o_positioning_done_flag(pd));
	sgs_selector #(.SAMPLE_LEN(SL)) i_sgs_selector (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata),
		.i_wstrb(4'hF), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
		.i_rready(i_rready), .i_ctrl_mode(md), .i_gain_select(gs), .i_torque_cmd(tq),
		.i_speed_cmd(sp), .i_actual_speed(ac), .i_pos_dev_enc(pe), .i_pos_dev_scale(ps),
		.i_pos_cmd_present(pc), .i_positioning_done_flag(pd), .o_second_gain(o_second_gain),
		.o_integ_second(o_integ_second));

	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	// ==========================================================================
	// helpers
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string m);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tmo();
		err_count++;
		$display("ERROR %0t bus wait ran out", $time);
		summarize();
	endtask

	// readies are combinational from registers, so the falling edge sees what the rising edge takes
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tk;
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge i_clk);
			ta = i_awvalid & o_awready;
			tw = i_wvalid & o_wready;
			tk = o_bvalid;
			br = o_bresp;
			@(posedge i_clk);
			if (ta) i_awvalid <= 1'b0;
			if (tw) i_wvalid <= 1'b0;
			if (tk) break;
		end
		i_bready <= 1'b0;
		if (n == 40) tmo();
	endtask

	task automatic axr(input logic [7:0] a);
		int n;
		logic ta, tk;
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(negedge i_clk);
			ta = i_arvalid & o_arready;
			tk = o_rvalid;
			rd = o_rdata;
			rr = o_rresp;
			@(posedge i_clk);
			if (ta) i_arvalid <= 1'b0;
			if (tk) break;
		end
		i_rready <= 1'b0;
		if (n == 40) tmo();
	endtask

	function automatic logic [7:0] pa(input int b, k);
		return ADDR_PAR0 + 8'(4 * (b + k));
	endfunction

	task automatic par(input int b, input int dly, lvl, hys);
		axw(pa(b, PAR_DLY), 32'(dly));
		axw(pa(b, PAR_LVL), 32'(lvl));
		axw(pa(b, PAR_HYS), 32'(hys));
	endtask

	// bounded wait for the gain output to reach e, then one comparison
	task automatic wt(input logic e, input int mx, input string m);
		for (int n = 0; n < mx && o_second_gain !== e; n++)
			@(negedge i_clk);
		chk(o_second_gain, e, m);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask

	// ==========================================================================
	// scenarios
	task automatic t_reset();
		chk(o_second_gain, 1'b0, "gain after reset");
		axr(ADDR_COND);
		chk(rd, 32'h0000_0000, "cond reset value");
		chk(rr, RESP_OKAY, "cond read resp");
		axr(8'h2C);
		chk(rr, RESP_SLVERR, "unmapped read");
		axw(8'h2C, 32'h0000_0001);
		chk(br, RESP_SLVERR, "unmapped write");
		$display("test reset done");
	endtask

	task automatic t_fixed();
		logic [3:0] cd [4] = '{C_FIX1, C_FIX2, C_INPUT, C_INVALID};
		for (int m = 0; m < 2; m++)
			for (int c = 0; c < 4; c++)
				for (int g = 0; g < 2; g++)
				begin
					axw(ADDR_COND, {28'h000_0000, cd[c]});
					i_sgs_host_model.drive(m ? MODE_FULL : MODE_POS, g[0], 0, 0, 0, 0, 0, 0, 1);
					wt((c == 1) || (c == 2 && g == 1), 8, "fixed or input code");
				end
		$display("test fixed codes done");
	endtask

	task automatic t_level();
		par(PAR_POS, 1, 100, 20);
		axw(ADDR_COND, {28'h000_0000, C_SPEED});
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 150, 0, 0, 0, 1);
		wt(1'b1, 5, "entry above level");
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 90, 0, 0, 0, 1);
		cyc(10);
		chk(o_second_gain, 1'b1, "inside hysteresis band");
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 50, 0, 0, 0, 1);
		cyc(DELAY_UNIT_CYC - 20);
		chk(o_second_gain, 1'b1, "return delay running");
		wt(1'b0, 40, "return after delay");
		$display("test level done");
	endtask

	task automatic t_pdev();
		par(PAR_POS, 0, 100, 20);
		axw(ADDR_COND, {28'h000_0000, C_POS_DEV});
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 0, 200, 0, 0, 1);
		wt(1'b1, 8, "encoder deviation");
		i_sgs_host_model.drive(MODE_FULL, 0, 0, 0, 0, 200, 0, 0, 1);
		wt(1'b0, 8, "scale ignores encoder");
		i_sgs_host_model.drive(MODE_FULL, 0, 0, 0, 0, 0, 200, 0, 1);
		wt(1'b1, 8, "scale deviation");
		$display("test deviation done");
	endtask

	task automatic t_done();
		axw(pa(PAR_POS, PAR_DLY), 32'h0000_0001);
		axw(ADDR_COND, {28'h000_0000, C_NOT_DONE});
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 0, 0, 0, 0, 0);
		wt(1'b1, 8, "not done gives second");
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 0, 0, 0, 0, 1);
		cyc(DELAY_UNIT_CYC - 20);
		chk(o_second_gain, 1'b1, "done still delayed");
		wt(1'b0, 40, "done returns first");
		$display("test positioning done");
	endtask

	// ramp of 1 r/min per sample is 100 units, of 2 is 200, against a level of 150
	// one drive plus SL-1 edges is exactly one sample window, so each window sees one step
	task automatic t_vel();
		par(PAR_VEL, 100, 150, 0);
		axw(ADDR_COND, 32'h0000_0401);
		i_sgs_host_model.drive(MODE_VEL, 0, 0, 0, 0, 0, 0, 0, 1);
		wt(1'b0, 4 * SL, "velocity own selector");
		for (int i = 1; i < 7; i++)
		begin
			i_sgs_host_model.drive(MODE_VEL, 0, 0, 16'(i), 0, 0, 0, 0, 1);
			cyc(SL - 1);
			chk(o_second_gain, 1'b0, "slow ramp below level");
		end
		for (int i = 1; i < 7; i++)
		begin
			i_sgs_host_model.drive(MODE_VEL, 0, 0, 16'(6 + 2 * i), 0, 0, 0, 0, 1);
			cyc(SL - 1);
		end
		chk(o_second_gain, 1'b1, "fast ramp above level");
		wt(1'b0, 4 * SL, "no return delay");
		$display("test velocity done");
	endtask

	task automatic t_trq();
		axw(ADDR_COND, 32'h0002_0101);
		i_sgs_host_model.drive(MODE_TRQ, 1, 0, 0, 0, 0, 0, 0, 1);
		wt(1'b1, 8, "torque input high");
		i_sgs_host_model.drive(MODE_TRQ, 0, 0, 0, 0, 0, 0, 0, 1);
		wt(1'b0, 8, "torque own selector");
		par(PAR_TRQ, 0, 10, 0);
		axw(ADDR_COND, 32'h0003_0101);
		cyc(3 * SL);
		chk(o_second_gain, 1'b0, "torque steady");
		i_sgs_host_model.drive(MODE_TRQ, 0, 50, 0, 0, 0, 0, 0, 1);
		wt(1'b1, 3 * SL, "torque step");
		wt(1'b0, 4 * SL, "torque settles");
		$display("test torque done");
	endtask

	task automatic t_c10();
		par(PAR_POS, 0, 100, 20);
		axw(ADDR_COND, {28'h000_0000, C_CMD_VEL});
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 0, 0, 0, 1, 1);
		wt(1'b1, 8, "command in action");
		chk(o_integ_second, 1'b1, "integrator in action");
		i_sgs_host_model.drive(MODE_POS, 0, 0, 0, 0, 0, 0, 0, 1);
		wt(1'b0, 12, "stall first gain");
		chk(o_integ_second, 1'b1, "integrator while settling");
		cyc(1);
		chk(o_integ_second, 1'b0, "integrator at stall");
		$display("test command speed done");
	endtask

	initial
	begin
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		@(negedge i_clk);
		t_reset();
		t_fixed();
		t_level();
		t_pdev();
		t_done();
		t_vel();
		t_trq();
		t_c10();
		summarize();
	end
endmodule // tb
